// file: rtl/byte_crc_bus_snooper.v
`timescale 1ns/10ps
`include "crc_snoop_defs.vh"
// snoops two read buses and folds mirrored byte reads into a crc
module byte_crc_bus_snooper #(
	parameter ADDR_W = 32,
	parameter DATA_W = 32,
	// mirrored alias windows and the normal windows behind them
	parameter [31:0] ROM_ALIAS_BASE = 32'h21000000,
	parameter [31:0] ROM_NORM_BASE = 32'h01000000,
	parameter [31:0] ROM_SPAN_MASK = 32'h0000FFFF,
	parameter [31:0] FLASH_ALIAS_BASE = 32'h20200000,
	parameter [31:0] FLASH_NORM_BASE = 32'h00200000,
	parameter [31:0] FLASH_SPAN_MASK = 32'h0007FFFF,
	parameter [31:0] RAM_ALIAS_BASE = 32'h30000000,
	parameter [31:0] RAM_NORM_BASE = 32'h20000000,
	parameter [31:0] RAM_SPAN_MASK = 32'h0001FFFF
) (
	// clock and reset
	input wire ref_clk,
	input wire rst,
	// code-data bus snoop, one completed transfer per cycle
	input wire code_valid,
	input wire code_read,
	input wire [ADDR_W-1:0] code_addr,
	input wire [1:0] code_size,
	input wire [DATA_W-1:0] code_rdata,
	input wire code_debug,
	input wire [1:0] code_req_zone,
	input wire [1:0] code_tgt_zone,
	input wire code_tgt_secure,
	input wire code_exe_only,
	output wire code_return_mask,
	// system bus snoop
	input wire sys_valid,
	input wire sys_read,
	input wire [ADDR_W-1:0] sys_addr,
	input wire [1:0] sys_size,
	input wire [DATA_W-1:0] sys_rdata,
	input wire sys_debug,
	input wire [1:0] sys_req_zone,
	input wire [1:0] sys_tgt_zone,
	input wire sys_tgt_secure,
	input wire sys_exe_only,
	output wire sys_return_mask,
	// control, selection and result access
	input wire clear_wr,
	input wire clear_bit,
	input wire sel_wr,
	input wire [1:0] sel_wdata,
	input wire result_wr,
	input wire [31:0] result_wdata,
	output wire [1:0] crc_poly_select_reg,
	output wire [31:0] crc_result_reg,
	// status
	output wire snoop_ready,
	output reg overrun,
	output wire busy,
	output reg [15:0] byte_count,
	output reg [ADDR_W-1:0] last_norm_addr
);

////////////////////////////////////////////////////////////////////////

// true when the address sits in any mirrored alias window
function alias_hit;
	input [31:0] a;
	begin
		alias_hit = ((a & ~ROM_SPAN_MASK) == ROM_ALIAS_BASE) // see RQ2
			| ((a & ~FLASH_SPAN_MASK) == FLASH_ALIAS_BASE)
			| ((a & ~RAM_SPAN_MASK) == RAM_ALIAS_BASE);
	end
endfunction

// maps a mirrored address back onto its normal location
function [31:0] unalias;
	input [31:0] a;
	begin
		if ((a & ~ROM_SPAN_MASK) == ROM_ALIAS_BASE)
			unalias = ROM_NORM_BASE | (a & ROM_SPAN_MASK); // see RQ2
		else if ((a & ~FLASH_SPAN_MASK) == FLASH_ALIAS_BASE)
			unalias = FLASH_NORM_BASE | (a & FLASH_SPAN_MASK);
		else if ((a & ~RAM_SPAN_MASK) == RAM_ALIAS_BASE)
			unalias = RAM_NORM_BASE | (a & RAM_SPAN_MASK);
		else
			unalias = a;
	end
endfunction

// a secure zone refuses reads issued by code of another zone
function zone_blocked;
	input [1:0] req_zone;
	input [1:0] tgt_zone;
	input tgt_secure;
	begin
		zone_blocked = (tgt_zone != `ZONE_NONE) && tgt_secure
			&& (req_zone != tgt_zone); // see RQ14
	end
endfunction

// picks the byte lane addressed by the low address bits, little endian
function [7:0] lane_byte;
	input [31:0] d;
	input [1:0] lane;
	begin
		case (lane)
			2'h0: lane_byte = d[7:0];
			2'h1: lane_byte = d[15:8];
			2'h2: lane_byte = d[23:16];
			2'h3: lane_byte = d[31:24];
			default: lane_byte = d[7:0];
		endcase
	end
endfunction

// top bit index for the selected width
function [4:0] top_bit;
	input [1:0] sel;
	begin
		case (sel)
			`SEL_CRC8: top_bit = `TOP_CRC8;
			`SEL_CRC16_ONE: top_bit = `TOP_CRC16;
			`SEL_CRC16_TWO: top_bit = `TOP_CRC16;
			default: top_bit = `TOP_CRC32;
		endcase
	end
endfunction

// generator polynomial for the selection
function [31:0] poly_of;
	input [1:0] sel;
	begin
		case (sel)
			`SEL_CRC8: poly_of = `POLY_CRC8; // see RQ7
			`SEL_CRC16_ONE: poly_of = `POLY_CRC16_ONE; // see RQ8
			`SEL_CRC16_TWO: poly_of = `POLY_CRC16_TWO; // see RQ8
			default: poly_of = `POLY_CRC32; // see RQ7
		endcase
	end
endfunction

// folds one byte msb first into a crc of the selected width
function [31:0] fold_byte;
	input [31:0] crc;
	input [7:0] d;
	input [1:0] sel;
	reg [31:0] c;
	reg [31:0] mask;
	reg [4:0] top;
	reg fb;
	integer i;
	begin
		top = top_bit(sel);
		mask = {32{1'b1}} >> (5'h1F - top);
		c = crc & mask;
		for (i = 7; i >= 0; i = i - 1) begin
			fb = c[top] ^ d[i];
			c = (c << 1) & mask;
			if (fb)
				c = c ^ poly_of(sel);
		end
		fold_byte = c;
	end
endfunction

////////////////////////////////////////////////////////////////////////

reg [31:0] result;
reg [1:0] poly_sel;
wire code_take;
wire sys_take;
wire [7:0] code_byte;
wire [7:0] sys_byte;
wire [17:0] buf_in;
wire buf_in_valid;
wire buf_in_ready;
wire buf_out_valid;
wire buf_out_ready;
wire [17:0] buf_out;
wire [31:0] after_first;
wire [31:0] after_both;
wire do_clear;
reg [31:0] next_result;

// both buses are watched in parallel; only completed reads count
assign code_take = code_valid && code_read // see RQ1
	&& alias_hit(code_addr) // see RQ3
	&& (code_size == `SIZE_BYTE) // see RQ5
	&& !code_debug // see RQ6
	&& !zone_blocked(code_req_zone, code_tgt_zone, code_tgt_secure); // see RQ14
assign sys_take = sys_valid && sys_read // see RQ1
	&& alias_hit(sys_addr) // see RQ3
	&& (sys_size == `SIZE_BYTE) // see RQ5
	&& !sys_debug // see RQ6
	&& !zone_blocked(sys_req_zone, sys_tgt_zone, sys_tgt_secure); // see RQ14

// exe-only and blocked reads hand zero to the processor, not the data
assign code_return_mask = code_valid && code_read && (code_exe_only // see RQ16
	|| zone_blocked(code_req_zone, code_tgt_zone, code_tgt_secure));
assign sys_return_mask = sys_valid && sys_read && (sys_exe_only // see RQ16
	|| zone_blocked(sys_req_zone, sys_tgt_zone, sys_tgt_secure));

// byte lanes; the code bus byte is folded before the system bus byte
assign code_byte = lane_byte(code_rdata, code_addr[`LANE_MSB:`LANE_LSB]);
assign sys_byte = lane_byte(sys_rdata, sys_addr[`LANE_MSB:`LANE_LSB]);
assign buf_in = {code_take, sys_take, code_byte, sys_byte};
assign buf_in_valid = code_take | sys_take;
assign snoop_ready = buf_in_ready;

////////////////////////////////////////////////////////////////////////

// the buffer absorbs the cycles in which software owns the result
crc_pair_buffer #(
	.WIDTH(18)
) u_buf (
	.ref_clk(ref_clk),
	.rst(rst),
	.in_valid(buf_in_valid),
	.in_ready(buf_in_ready),
	.in_data(buf_in),
	.out_valid(buf_out_valid),
	.out_ready(buf_out_ready),
	.out_data(buf_out)
);

// folding stalls while software clears or writes the result, so a
// byte that meets a clear is folded after it rather than lost
assign do_clear = clear_wr && clear_bit; // see RQ9
assign buf_out_ready = !do_clear && !result_wr;
assign busy = buf_out_valid;

// up to two bytes per entry, folded back to back in one cycle
assign after_first = buf_out[17] ? fold_byte(result, buf_out[15:8], poly_sel) : result;
assign after_both = buf_out[16] ? fold_byte(after_first, buf_out[7:0], poly_sel) : after_first;

// next result: clear first, then software write, then fold
always @* begin
	next_result = result;
	if (do_clear)
		next_result = `RESULT_RESET; // see RQ9
	else if (result_wr)
		next_result = result_wdata; // see RQ11
	else if (buf_out_valid)
		next_result = after_both; // see RQ4
end

////////////////////////////////////////////////////////////////////////

// result and selection registers
always @(posedge ref_clk) begin
	if (rst) begin
		result <= `RESULT_RESET; // see RQ17
		poly_sel <= `SEL_RESET; // see RQ17
	end else begin
		result <= next_result; // see RQ18
		if (sel_wr)
			poly_sel <= sel_wdata; // see RQ10
	end
end

assign crc_result_reg = result; // see RQ4
assign crc_poly_select_reg = poly_sel;

// status: folded byte count, last de-aliased address, lost bytes;
// a full buffer can only drop, since a snooped bus cannot be held
always @(posedge ref_clk) begin
	if (rst) begin
		byte_count <= 16'h0000;
		overrun <= 1'b0;
		last_norm_addr <= {ADDR_W{1'b0}};
	end else begin
		if (do_clear)
			byte_count <= 16'h0000;
		else if (buf_out_valid && buf_out_ready)
			byte_count <= byte_count + {15'h0000, buf_out[17]} + {15'h0000, buf_out[16]};
		if (buf_in_valid && !buf_in_ready)
			overrun <= 1'b1;
		else if (do_clear)
			overrun <= 1'b0;
		if (sys_take)
			last_norm_addr <= unalias(sys_addr);
		else if (code_take)
			last_norm_addr <= unalias(code_addr);
	end
end

endmodule // byte_crc_bus_snooper

// file: rtl/crc_pair_buffer.v
`timescale 1ns/10ps
// two-entry buffer, registered storage, honest full and empty
module crc_pair_buffer #(
	parameter WIDTH = 18
) (
	// clock and reset
	input wire ref_clk,
	input wire rst,
	// filling side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// draining side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);

reg [WIDTH-1:0] slot0;
reg [WIDTH-1:0] slot1;
reg rd_ptr;
reg wr_ptr;
reg [1:0] count;
wire push;
wire pop;

// handshake terms
assign in_ready = (count != 2'h2);
assign out_valid = (count != 2'h0);
assign out_data = rd_ptr ? slot1 : slot0;
assign push = in_valid & in_ready;
assign pop = out_valid & out_ready;

// storage and pointers; a push and pop together keep the count
always @(posedge ref_clk) begin
	if (rst) begin
		slot0 <= {WIDTH{1'b0}};
		slot1 <= {WIDTH{1'b0}};
		rd_ptr <= 1'b0;
		wr_ptr <= 1'b0;
		count <= 2'h0;
	end else begin
		if (push && !wr_ptr)
			slot0 <= in_data;
		if (push && wr_ptr)
			slot1 <= in_data;
		if (push)
			wr_ptr <= ~wr_ptr;
		if (pop)
			rd_ptr <= ~rd_ptr;
		if (push && !pop)
			count <= count + 2'h1;
		else if (pop && !push)
			count <= count - 2'h1;
	end
end

endmodule // crc_pair_buffer

// file: rtl/crc_snoop_defs.vh
// What this block does
// RQ1: watch reads on code-data and system buses
// RQ2: rom, flash, ram each have mirrored alias
// RQ3: capture only reads inside mirrored alias range
// RQ4: fold captured byte, result always readable
// RQ5: half-word and word reads are discarded
// RQ6: debugger reads never update the result
// RQ7: crc8 poly 07, crc32 poly 04C11DB7
// RQ8: crc16 variants with polys 8005 and 1021
// RQ9: writing one to clear bit zeroes result
// RQ10: selection register picks one of four polys
// RQ11: result register writable for nested save/restore
// RQ12: software saves result before reusing the engine
// RQ13: software reads each byte singly via mirror
// RQ14: cross-zone reads of secure memory are blocked
// RQ15: same-zone exe-only mirrored reads still feed crc
// RQ16: exe-only read data never returns to processor
// RQ17: reset gives zero result and crc8 selected
// RQ18: each byte folded one cycle after transfer; code holds up to two entries in its buffer while software clears or writes the result, then drops
`ifndef CRC_SNOOP_DEFS_VH
`define CRC_SNOOP_DEFS_VH

// polynomial selection codes
`define SEL_W 2
`define SEL_CRC8 2'h0
`define SEL_CRC16_ONE 2'h1
`define SEL_CRC16_TWO 2'h2
`define SEL_CRC32 2'h3

// generator polynomials, right aligned
`define POLY_CRC8 32'h00000007
`define POLY_CRC16_ONE 32'h00008005
`define POLY_CRC16_TWO 32'h00001021
`define POLY_CRC32 32'h04C11DB7

// top bit index of each result width
`define TOP_CRC8 5'h07
`define TOP_CRC16 5'h0F
`define TOP_CRC32 5'h1F

// transfer size encoding on the snooped buses
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2

// reset values
`define RESULT_RESET 32'h00000000
`define SEL_RESET `SEL_CRC8

// byte lane field of an address
`define LANE_LSB 0
`define LANE_MSB 1

// zone code meaning memory owned by no zone
`define ZONE_NONE 2'h0

`endif

// file: sim/cpu_read_master.sv
`timescale 1ns/10ps
// processor side: one completed read per cycle that go is high
module cpu_read_master #(
	parameter [7:0] K = 8'h5A,
	parameter [31:0] X = 32'h00000000
) (
	// clock
	input wire ref_clk,
	// command
	input wire go,
	input wire [31:0] a,
	input wire [1:0] s,
	input wire [6:0] f,
	// snooped bus
	output reg valid = 1'b0,
	output reg rd = 1'b0,
	output reg [31:0] addr = 32'h0,
	output reg [1:0] size = 2'h0,
	output reg [31:0] rdata = 32'h0,
	output reg [6:0] fl = 7'h0
);
	// byte follows the address; an idle bus inverts its leftovers every cycle, so every second idle cycle shows the stale data again
	always @(posedge ref_clk) begin
		valid <= go;
		rd <= go;
		addr <= go ? a ^ X : ~addr;
		size <= go ? s : ~size;
		rdata <= go ? {4{a[7:0] ^ K}} ^ ~(32'hFF << {a[1:0], 3'h0}) : ~rdata;
		fl <= go ? f : ~fl;
	end
endmodule // cpu_read_master

// file: sim/crc_snoop_checker.sv
`timescale 1ns/10ps
// port rules of the snooper
module crc_snoop_checker (
	// clock and reset
	input wire ref_clk,
	input wire rst,
	// code bus, and the system bus valid
	input wire code_valid,
	input wire code_read,
	input wire [31:0] code_addr,
	input wire [1:0] code_size,
	input wire code_debug,
	input wire [1:0] code_req_zone,
	input wire [1:0] code_tgt_zone,
	input wire code_tgt_secure,
	input wire code_exe_only,
	input wire code_return_mask,
	input wire sys_valid,
	// control and status
	input wire clear_wr,
	input wire clear_bit,
	input wire result_wr,
	input wire [31:0] result_wdata,
	input wire [1:0] crc_poly_select_reg,
	input wire [31:0] crc_result_reg,
	input wire busy,
	input wire [15:0] byte_count
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// lone code read, empty buffer, no writes: only a capture may move the result
	wire clr = clear_wr & clear_bit;
	wire quiet = code_valid & code_read & !busy & !clr & !result_wr & !sys_valid;
	wire hit = quiet & code_size == 2'h0 & code_addr[31:16] == 16'h2100 & !code_debug & !code_tgt_secure;
	////////////////////////
	property p_reset; $fell(rst) |-> crc_result_reg == 32'h0 && crc_poly_select_reg == 2'h0; endproperty
	a_reset: assert property (p_reset) else $error("reset value wrong");
	property p_clear; clr |=> crc_result_reg == 32'h0 && byte_count == 16'h0; endproperty
	a_clear: assert property (p_clear) else $error("clear missed");
	property p_write; result_wr && !clr |=> crc_result_reg == $past(result_wdata); endproperty
	a_write: assert property (p_write) else $error("result write lost");
	property p_size; quiet && code_size != 2'h0 |=> $stable(crc_result_reg); endproperty
	a_size: assert property (p_size) else $error("wide read folded");
	property p_debug; quiet && code_debug |=> $stable(crc_result_reg); endproperty
	a_debug: assert property (p_debug) else $error("debug read folded");
	property p_zone; quiet && code_tgt_secure && code_tgt_zone != 2'h0 && code_req_zone != code_tgt_zone
		|=> $stable(crc_result_reg); endproperty
	a_zone: assert property (p_zone) else $error("blocked read folded");
	property p_fold; hit |=> busy ##1 byte_count == $past(byte_count, 2) + 16'h1; endproperty
	a_fold: assert property (p_fold) else $error("byte not folded in time");
	property p_mask; code_valid && code_read && code_exe_only |-> code_return_mask; endproperty
	a_mask: assert property (p_mask) else $error("exe-only data reached cpu");
	c_hit: cover property (hit);
	c_clr: cover property (clr);
	c_fill: cover property (busy ##1 busy);
endmodule // crc_snoop_checker

bind byte_crc_bus_snooper crc_snoop_checker i_crc_snoop_checker (.*);

// file: sim/testbench.sv
`timescale 1ns/10ps
// drives the snooper through two read masters and checks the crc
module testbench;
	reg ref_clk = 1'b0;
	reg rst = 1'b1;
	reg [1:0] go = 2'h0;
	reg [31:0] a = 32'h0;
	reg [1:0] s = 2'h0;
	reg [6:0] f = 7'h0;
	reg clear_wr = 1'b0, clear_bit = 1'b0, sel_wr = 1'b0, result_wr = 1'b0;
	reg [1:0] sel_wdata = 2'h0;
	reg [31:0] result_wdata = 32'h0;
	reg [31:0] exp;
	wire code_valid, code_read, code_debug, code_tgt_secure, code_exe_only, code_return_mask;
	wire sys_valid, sys_read, sys_debug, sys_tgt_secure, sys_exe_only, sys_return_mask;
	wire [31:0] code_addr, code_rdata, sys_addr, sys_rdata, crc_result_reg, last_norm_addr;
	wire [1:0] code_size, code_req_zone, code_tgt_zone, sys_size, sys_req_zone, sys_tgt_zone, crc_poly_select_reg;
	wire snoop_ready, overrun, busy;
	wire [15:0] byte_count;
	integer num_errors = 0, total_checks = 0, cyc = 0;
	// sys master lands in the ram mirror by flipping address bits
	cpu_read_master i_cpu_read_master (.ref_clk(ref_clk), .go(go[0]), .a(a), .s(s), .f(f), .valid(code_valid),
		.rd(code_read), .addr(code_addr), .size(code_size), .rdata(code_rdata),
		.fl({code_debug, code_req_zone, code_tgt_zone, code_tgt_secure, code_exe_only}));
	cpu_read_master #(.K(8'hC3), .X(32'h11000000)) i_cpu_read_master_sys (.ref_clk(ref_clk), .go(go[1]), .a(a),
		.s(s), .f(f), .valid(sys_valid), .rd(sys_read), .addr(sys_addr), .size(sys_size), .rdata(sys_rdata),
		.fl({sys_debug, sys_req_zone, sys_tgt_zone, sys_tgt_secure, sys_exe_only}));
	byte_crc_bus_snooper i_byte_crc_bus_snooper (.*);
	// clock
	initial forever #4 ref_clk = ~ref_clk;
	// hang guard
	always @(posedge ref_clk) begin
		cyc = cyc + 1;
		if (cyc == 1000) begin
			num_errors = num_errors + 1;
			wrap_up;
		end
	end
	////////////////////////
	task chk(input [255:0] n, input [31:0] e, input [31:0] g);
		begin
			total_checks = total_checks + 1;
			if (g !== e) begin
				num_errors = num_errors + 1;
				$display("[FAIL] %0s expected %h seen %h", n, e, g);
			end
		end
	endtask
	task wrap_up;
		begin
			$display("checks %0d errors %0d", total_checks, num_errors);
			if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
			else $display("[ FAIL ]");
			$finish;
		end
	endtask
	// reference crc: msb first, unreflected, no final xor
	function [31:0] fold(input [31:0] c, input [7:0] d, input [1:0] sel);
		integer i, w;
		reg [31:0] p;
		begin
			w = sel == 2'h0 ? 8 : sel == 2'h3 ? 32 : 16;
			p = sel == 2'h0 ? 32'h07 : sel == 2'h1 ? 32'h8005 : sel == 2'h2 ? 32'h1021 : 32'h04C11DB7;
			for (i = 7; i >= 0; i = i - 1)
				c = c[w - 1] ^ d[i] ? (c << 1) ^ p : c << 1;
			fold = c & (32'hFFFFFFFF >> (32 - w));
		end
	endfunction
	// go stays up between calls so reads can run back to back
	task rd(input [1:0] g, input [31:0] ad, input [1:0] sz, input [6:0] fg);
		begin
			@(posedge ref_clk);
			go <= g;
			a <= ad;
			s <= sz;
			f <= fg;
		end
	endtask
	task idle;
		begin
			@(posedge ref_clk);
			go <= 2'h0;
			repeat (4) @(posedge ref_clk);
		end
	endtask
	task ctl(input c, input sw, input [1:0] sv, input rw, input [31:0] rv);
		begin
			@(posedge ref_clk);
			clear_wr <= c;
			clear_bit <= c;
			sel_wr <= sw;
			sel_wdata <= sv;
			result_wr <= rw;
			result_wdata <= rv;
			@(posedge ref_clk);
			clear_wr <= 1'b0;
			sel_wr <= 1'b0;
			result_wr <= 1'b0;
			// registers update on this edge; look once they have settled
			@(negedge ref_clk);
		end
	endtask
	////////////////////////
	task t_polys;
		integer p, j;
		begin
			for (p = 0; p < 4; p = p + 1) begin
				ctl(1'b1, 1'b1, p[1:0], 1'b0, 32'h0);
				chk("select", p, {30'h0, crc_poly_select_reg});
				exp = 32'h0;
				for (j = 0; j < 3; j = j + 1) begin
					rd(2'h1, 32'h21000010 + j, 2'h0, 7'h0);
					exp = fold(exp, 8'h10 + j[7:0] ^ 8'h5A, p[1:0]);
				end
				idle;
				chk("crc", exp, crc_result_reg);
				chk("count", 32'h3, {16'h0, byte_count});
			end
		end
	endtask
	// half, word, plain address, debugger, other zone: none may count
	task t_refuse;
		begin
			exp = crc_result_reg;
			rd(2'h1, 32'h21000020, 2'h1, 7'h0);
			rd(2'h1, 32'h21000024, 2'h2, 7'h0);
			rd(2'h1, 32'h01000028, 2'h0, 7'h0);
			rd(2'h1, 32'h2100002C, 2'h0, 7'h40);
			rd(2'h1, 32'h21000030, 2'h0, 7'h1A);
			idle;
			chk("kept", exp, crc_result_reg);
		end
	endtask
	// save, load, exe-only same-zone byte, restore
	task t_nest;
		reg [31:0] saved;
		begin
			saved = crc_result_reg;
			ctl(1'b0, 1'b1, 2'h3, 1'b1, 32'h89ABCDEF);
			chk("load", 32'h89ABCDEF, crc_result_reg);
			rd(2'h1, 32'h20200041, 2'h0, 7'h17);
			@(posedge ref_clk);
			go <= 2'h0;
			@(negedge ref_clk);
			chk("mask", 32'h1, {31'h0, code_return_mask});
			idle;
			chk("exe", fold(32'h89ABCDEF, 8'h1B, 2'h3), crc_result_reg);
			ctl(1'b0, 1'b0, 2'h3, 1'b1, saved);
			chk("back", saved, crc_result_reg);
		end
	endtask
	// both buses at once, then overfill the buffer
	task t_both;
		begin
			ctl(1'b1, 1'b1, 2'h1, 1'b0, 32'h0);
			rd(2'h3, 32'h21000053, 2'h0, 7'h0);
			idle;
			exp = fold(fold(32'h0, 8'h09, 2'h1), 8'h90, 2'h1);
			chk("both", exp, crc_result_reg);
			// a held result write stalls folding, so the third entry has no room
			result_wr <= 1'b1;
			result_wdata <= 32'h0;
			repeat (3) rd(2'h3, 32'h21000060, 2'h0, 7'h0);
			idle;
			result_wr <= 1'b0;
			repeat (4) @(posedge ref_clk);
			chk("drop", 32'h1, {31'h0, overrun});
			ctl(1'b1, 1'b1, 2'h1, 1'b0, 32'h0);
			chk("clr", 32'h0, {overrun, crc_result_reg[30:0]});
		end
	endtask
	////////////////////////
	initial begin
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		chk("rst", 32'h80000000, {snoop_ready, crc_poly_select_reg, crc_result_reg[28:0]});
		t_polys;
		t_refuse;
		t_nest;
		t_both;
		wrap_up;
	end
endmodule // testbench
